// *** hdl/tsspc_top.sv ***
// Timer pin control, request flags, start synchronizer and auto-stop.
// Assumes timer cores on clk report underflows as one-cycle pulses and
// the sequencer drives skip and acknowledge pulses on clk.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tsspc_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [tsspc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic presc_out,
   input wire logic timer2_src,
   input wire logic [2:0] underflow,
   input wire logic pwm_in,
   input wire logic port_c_latch,
   input wire logic timer_io_pin_in,
   output logic timer_io_pin_out,
   output logic timer_io_pin_oe,
   input wire logic ext_int_pin,
   input wire logic [2:0] skip_req,
   output logic [2:0] skip_taken,
   input wire logic [2:0] irq_ack,
   output logic [2:0] irq_req,
   output logic timer1_count_pulse,
   output logic timer2_count_pulse,
   output logic ext_int_event
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] timer1_ctrl;
      logic [3:0] timer2_ctrl;
      logic [3:0] pin_edge_lcd_timer_ctrl;
      logic [3:0] int_ctrl_one;
      logic [2:0] irq_enable;
      logic [2:0] req_flag;
      logic sync_set;
      logic int_s1;
      logic int_s2;
      logic int_prev;
      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      logic presc_prev;
      logic t2_prev;
      logic t2_armed;
      logic pwm_q;
      logic resp;
      logic [31:0] rdata;
   } tsspc_state_t;

   tsspc_state_t st_ff;
   tsspc_state_t nxt_st;
   logic req;
   logic wr_en;
   logic t1_running;
   logic t1_pin_src;
   logic t1_edge;
   logic int_valid;
   logic t2_running;

   // ---------------------------------------------------------------
   // Combinational helpers
   // ---------------------------------------------------------------
   // Bus handshake: one wait cycle, answer on the second edge
   // Writes land on the answer edge, so a held request counts once
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~st_ff.resp;
   assign wr_en = avs_write & st_ff.resp & avs_byteenable[0];
   assign avs_readdata = st_ff.rdata;

   // Timer one gating and source edge
   assign t1_pin_src = st_ff.timer1_ctrl[1:0] == tsspc_pkg::T1_SRC_PIN;
   assign t1_running = st_ff.timer1_ctrl[tsspc_pkg::T1_RUN]
      & (~st_ff.int_ctrl_one[tsspc_pkg::SYNC_START_EN]
      | st_ff.sync_set);
   always_comb begin
      if (t1_pin_src) begin
         // Falling edge unless the rising edge is chosen
         if (st_ff.pin_edge_lcd_timer_ctrl[tsspc_pkg::PIN_EDGE_RISE]) begin
            t1_edge = st_ff.pin_s2 & ~st_ff.pin_prev;
         end else begin
            t1_edge = ~st_ff.pin_s2 & st_ff.pin_prev;
         end
      end else begin
         t1_edge = presc_out & ~st_ff.presc_prev;
      end
   end
   assign timer1_count_pulse = t1_running & t1_edge;

   // Valid waveform on the int pin, same test as the interrupt
   assign int_valid = st_ff.int_ctrl_one[tsspc_pkg::INT_EDGE_RISE] ?
      (st_ff.int_s2 & ~st_ff.int_prev) : (~st_ff.int_s2 & st_ff.int_prev);
   assign ext_int_event = int_valid;

   // Timer two counts rising edges once a falling edge was seen
   assign t2_running = st_ff.timer2_ctrl[tsspc_pkg::T2_RUN];
   assign timer2_count_pulse = t2_running & st_ff.t2_armed
      & timer2_src & ~st_ff.t2_prev;

   // Flags to interrupt or skip path
   assign irq_req = st_ff.req_flag & st_ff.irq_enable;
   assign skip_taken = skip_req & st_ff.req_flag
      & ~st_ff.irq_enable;

   // Shared pin: driver off while the pin feeds timer one
   assign timer_io_pin_oe = ~t1_pin_src;
   assign timer_io_pin_out = st_ff.timer2_ctrl[tsspc_pkg::T2_PIN_PWM] ?
      st_ff.pwm_q : port_c_latch;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // Synchronisers and edge history
      nxt_st.int_s1 = ext_int_pin;
      nxt_st.int_s2 = st_ff.int_s1;
      nxt_st.int_prev = st_ff.int_s2;
      nxt_st.pin_s1 = timer_io_pin_in;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.pin_prev = st_ff.pin_s2;
      nxt_st.presc_prev = presc_out;
      nxt_st.t2_prev = timer2_src;
      // Bus response
      nxt_st.resp = req & ~st_ff.resp;
      if (avs_read & ~st_ff.resp) begin
         unique case (avs_address)
            tsspc_pkg::OFS_TIMER1_CTRL:
               nxt_st.rdata = {28'h0, st_ff.timer1_ctrl};
            tsspc_pkg::OFS_TIMER2_CTRL:
               nxt_st.rdata = {28'h0, st_ff.timer2_ctrl};
            tsspc_pkg::OFS_PIN_EDGE:
               nxt_st.rdata = {28'h0, st_ff.pin_edge_lcd_timer_ctrl};
            tsspc_pkg::OFS_INT_CTRL_ONE:
               nxt_st.rdata = {28'h0, st_ff.int_ctrl_one};
            tsspc_pkg::OFS_IRQ_ENABLE:
               nxt_st.rdata = {29'h0, st_ff.irq_enable};
            tsspc_pkg::OFS_STATUS:
               nxt_st.rdata = {28'h0, st_ff.sync_set, st_ff.req_flag};
            default: nxt_st.rdata = 32'h0;
         endcase
      end
      // Register writes
      if (wr_en) begin
         unique case (avs_address)
            tsspc_pkg::OFS_TIMER1_CTRL:
               nxt_st.timer1_ctrl = avs_writedata[3:0];
            tsspc_pkg::OFS_TIMER2_CTRL:
               nxt_st.timer2_ctrl = avs_writedata[3:0];
            tsspc_pkg::OFS_PIN_EDGE:
               nxt_st.pin_edge_lcd_timer_ctrl = avs_writedata[3:0];
            tsspc_pkg::OFS_INT_CTRL_ONE:
               nxt_st.int_ctrl_one = avs_writedata[3:0];
            tsspc_pkg::OFS_IRQ_ENABLE: nxt_st.irq_enable = avs_writedata[2:0];
            default: ;
         endcase
      end
      // Auto-stop disarms on timer one underflow in sync mode
      if (underflow[0] & st_ff.int_ctrl_one[tsspc_pkg::SYNC_START_EN]
          & st_ff.timer1_ctrl[tsspc_pkg::T1_AUTO_STOP]) begin
         nxt_st.timer1_ctrl[tsspc_pkg::T1_AUTO_STOP] = 1'b0;
      end
      // Start synchronizer: set by valid edge, held until disabled or cleared by timer one underflow with auto-stop
      if (~nxt_st.int_ctrl_one[tsspc_pkg::SYNC_START_EN]) begin
         nxt_st.sync_set = 1'b0;
      end else if (underflow[0]
                   & st_ff.timer1_ctrl[tsspc_pkg::T1_AUTO_STOP]) begin
         nxt_st.sync_set = 1'b0;
      end else if (int_valid) begin
         nxt_st.sync_set = 1'b1;
      end
      // Request flags: set wins over clear
      nxt_st.req_flag = underflow
         | (st_ff.req_flag & ~(irq_ack & irq_req)
         & ~skip_taken);
      // Timer two waits for a falling source edge after start
      if (~t2_running) begin
         nxt_st.t2_armed = 1'b0;
      end else if (~timer2_src & st_ff.t2_prev) begin
         nxt_st.t2_armed = 1'b1;
      end
      // PWM held when stop meets underflow, hiding the hazard
      if (~(underflow[1] & wr_en
            & avs_address == tsspc_pkg::OFS_TIMER2_CTRL
            & ~avs_writedata[tsspc_pkg::T2_RUN])) begin
         nxt_st.pwm_q = pwm_in;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff <= '0;
         st_ff.timer1_ctrl <= tsspc_pkg::RST_CTRL;
         st_ff.req_flag <= tsspc_pkg::RST_FLAGS;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_pin_drive_off: assert property (
      t1_pin_src |-> !timer_io_pin_oe)
      else $error("pin driven while it feeds timer one");
   a_pin_pwm_sel: assert property (
      timer_io_pin_oe && st_ff.timer2_ctrl[3]
      |-> timer_io_pin_out == st_ff.pwm_q)
      else $error("pin does not carry PWM");
   a_flag_set_uf: assert property (
      underflow[2] |=> st_ff.req_flag[2])
      else $error("flag missed an underflow");
   a_flag_skip_clr: assert property (
      skip_taken[0] && !underflow[0] |=> !st_ff.req_flag[0])
      else $error("skip did not clear flag");
   a_irq_no_skip: assert property (
      st_ff.irq_enable[1] |-> !skip_taken[1])
      else $error("skip taken on interrupt flag");
   a_sync_gate: assert property (
      st_ff.int_ctrl_one[0] && !st_ff.sync_set |-> !timer1_count_pulse)
      else $error("count pulse before start sync");
   a_sync_sets: assert property (
      int_valid && st_ff.int_ctrl_one[0] && !underflow[0] && !wr_en
      |=> st_ff.sync_set)
      else $error("sync not set by int edge");
   a_sync_hold: assert property (
      st_ff.sync_set && !wr_en && !underflow[0] |=> st_ff.sync_set)
      else $error("sync dropped on its own");
   a_auto_stop: assert property (
      st_ff.sync_set && st_ff.timer1_ctrl[3] && underflow[0]
      |=> !st_ff.sync_set
      && (!timer1_count_pulse || !st_ff.int_ctrl_one[0]))
      else $error("auto-stop did not stop timer one");
   a_pin_fall_cnt: assert property (
      timer1_count_pulse && t1_pin_src && !st_ff.pin_edge_lcd_timer_ctrl[0]
      |-> !st_ff.pin_s2 && st_ff.pin_prev)
      else $error("pin count not on falling edge");
   a_t2_first_fall: assert property (
      $rose(t2_running) && timer2_src |-> !timer2_count_pulse [*2])
      else $error("timer two counted before a falling edge");
   a_flag_irq_clr: assert property (
      irq_ack[0] && irq_req[0] && !underflow[0] |=> !st_ff.req_flag[0])
      else $error("interrupt did not clear flag");
   a_sync_off: assert property (
      !st_ff.int_ctrl_one[0] |-> !st_ff.sync_set)
      else $error("sync set while disabled");
   a_pin_rise_cnt: assert property (
      timer1_count_pulse && t1_pin_src && st_ff.pin_edge_lcd_timer_ctrl[0]
      |-> st_ff.pin_s2 && !st_ff.pin_prev)
      else $error("pin count not on rising edge");
   a_pwm_follow: assert property (
      !underflow[1] |=> st_ff.pwm_q == $past(pwm_in))
      else $error("PWM level not carried to pin");

   // Main scenarios reached
   c_sync_start: cover property (
      st_ff.int_ctrl_one[0] ##1 $rose(st_ff.sync_set));
   c_auto_stop: cover property (
      $fell(st_ff.sync_set) && st_ff.int_ctrl_one[0]);
   c_skip: cover property (|skip_taken);
   c_pwm_pin: cover property (timer_io_pin_oe && st_ff.timer2_ctrl[3]);
   c_t2_count: cover property (timer2_count_pulse);
endmodule // tsspc_top

// *** hdl/tsspc_pkg.sv ***
// Package for the timer support block: register map, field positions,
// reset values. Assumes a 32-bit Avalon-MM slave with byte addresses.
package tsspc_pkg;
   localparam int ADDR_W = 5;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_TIMER1_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_TIMER2_CTRL = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_PIN_EDGE = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_INT_CTRL_ONE = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
   // Field positions
   localparam int T1_SRC_LO = 0;
   localparam int T1_RUN = 2;
   localparam int T1_AUTO_STOP = 3;
   localparam int T2_RUN = 1;
   localparam int T2_PIN_PWM = 3;
   localparam int PIN_EDGE_RISE = 0;
   localparam int SYNC_START_EN = 0;
   localparam int INT_EDGE_RISE = 1;
   localparam int ST_SYNC_SET = 3;
   // Timer one source code that selects the pin
   localparam logic [1:0] T1_SRC_PIN = 2'h3;
   // Reset values
   localparam logic [3:0] RST_CTRL = 4'h0;
   localparam logic [2:0] RST_FLAGS = 3'h0;
endpackage

// *** verif/tsspc_far_model.sv ***
// Far-side model: timer cores' underflow pulses and the shared pin.
// Assumes the bench requests underflows on clk and sets the pin level.
`timescale 1ns/1ps
module tsspc_far_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] fire,
   input wire logic ext_lvl,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic [2:0] underflow,
   output logic pin_in
);
   // -------------------------------------------------------------
   // Underflow pulses and pin resolution
   // -------------------------------------------------------------
   // One-cycle underflow pulse per request
   always_ff @(posedge clk) begin
      underflow <= reset ? 3'h0 : fire;
   end
   // Device drives while enabled, else the outside source
   assign pin_in = pin_oe ? pin_out : ext_lvl;
   // Timer cores are never read, loaded or reloaded by the bench,
   // so no access meets a running count or an underflow
endmodule // tsspc_far_model

// *** verif/tb_top.sv ***
// Self-checking bench for the timer pin and start logic.
// Assumes the far-side model file is compiled before this one.
`timescale 1ns/1ps
module tb_top;
   // -------------------------------------------------------------
   // Signals, clock, pulse counters
   // -------------------------------------------------------------
   logic clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, wreq, presc = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic pwm = 1'b0, latch = 1'b0, ext_lvl = 1'b0, pin_in, pin_out, pin_oe;
   logic int_pin = 1'b0, p1, p2, evt;
   logic [2:0] skip_req = 3'h0, skip_taken, ack = 3'h0, irq, fire = 3'h0;
   logic [2:0] uf, m;
   logic [31:0] rn;
   logic t2src = 1'b0;
   int n_errors = 0, cmp_count = 0, cnt = 0, cnt2 = 0, c0, i;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (p1 === 1'b1) cnt <= cnt + 1;
   always @(posedge clk) if (p2 === 1'b1) cnt2 <= cnt2 + 1;
   tsspc_far_model far (.clk(clk), .reset(reset), .fire(fire),
      .ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
      .underflow(uf), .pin_in(pin_in));
   tsspc_top DUT (.clk(clk), .reset(reset), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .presc_out(presc), .timer2_src(t2src), .underflow(uf), .pwm_in(pwm),
      .port_c_latch(latch), .timer_io_pin_in(pin_in),
      .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe),
      .ext_int_pin(int_pin), .skip_req(skip_req), .skip_taken(skip_taken),
      .irq_ack(ack), .irq_req(irq), .timer1_count_pulse(p1),
      .timer2_count_pulse(p2), .ext_int_event(evt));
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [3:0] d);
      int k;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= {28'h0, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      if (k >= 50) begin
         n_errors++; // Bus hang counts against the run
      end
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Square wave, n periods: 0 prescaler, 1 pin, 2 timer two source
   task automatic wave(input int sel, input int n);
      logic lv;
      for (int h = 0; h < 2 * n; h++) begin
         lv = (h % 2 == 0);
         if (sel == 1) ext_lvl <= lv;
         else if (sel == 2) t2src <= lv;
         else presc <= lv;
         tick(2);
      end
   endtask
   // -------------------------------------------------------------
   // Main sequence and hang guard
   // -------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial begin
      rv = $urandom(32'hA6F3);
      tick(16);
      reset <= 1'b0;
      bus(0, tsspc_pkg::OFS_STATUS, 4'h0);
      check("status_rst", rv, 32'h0);
      check("oe_rst", pin_oe, 1'b1);
      bus(0, 5'h18, 4'h0);
      check("unmapped", rv, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 6; k++) begin
         rn = $urandom;
         pwm <= rn[0];
         latch <= rn[2] ? 1'b0 : rn[1];
         bus(1, tsspc_pkg::OFS_TIMER2_CTRL, {rn[2], 3'h0});
         bus(1, tsspc_pkg::OFS_TIMER1_CTRL, {rn[7], 1'b0, rn[5:4]});
         tick(3);
         check("pin_out", pin_out, rn[2] ? rn[0] : rn[1]);
         check("pin_oe", pin_oe, rn[5:4] != 2'h3);
         bus(0, tsspc_pkg::OFS_TIMER2_CTRL, 4'h0);
         check("ctrl2", rv, {28'h0, rn[2], 3'h0});
      end
      $display("test pin_select done");
      for (int k = 0; k < 3; k++) begin
         m = 3'h1 << k;
         bus(1, tsspc_pkg::OFS_IRQ_ENABLE, {1'b0, (k == 0) ? m : 3'h0});
         fire <= m;
         tick(1);
         fire <= 3'h0;
         tick(2);
         bus(0, tsspc_pkg::OFS_STATUS, 4'h0);
         check("flag_set", rv[2:0], m);
         if (k == 0) begin
            check("irq_req", irq, m);
            ack <= m;
         end else begin
            skip_req <= m;
            #1 check("skip_taken", skip_taken, m);
         end
         tick(1);
         ack <= 3'h0;
         skip_req <= 3'h0;
         bus(0, tsspc_pkg::OFS_STATUS, 4'h0);
         check("flag_clr", rv[2:0], 3'h0);
      end
      $display("test flags done");
      bus(1, tsspc_pkg::OFS_TIMER1_CTRL, 4'h4);
      bus(1, tsspc_pkg::OFS_INT_CTRL_ONE, 4'h3);
      c0 = cnt;
      wave(0, 3);
      check("gated", cnt - c0, 0);
      int_pin <= 1'b1;
      for (i = 0; i < 20 && evt !== 1'b1; i++) tick(1);
      check("int_event", i < 20, 1'b1);
      tick(2);
      c0 = cnt;
      wave(0, 4);
      check("counted", cnt - c0, 4);
      int_pin <= 1'b0;
      tick(6);
      bus(0, tsspc_pkg::OFS_STATUS, 4'h0);
      check("sync_held", rv[3], 1'b1);
      bus(1, tsspc_pkg::OFS_TIMER1_CTRL, 4'hC);
      fire <= 3'h1;
      tick(1);
      fire <= 3'h0;
      tick(2);
      bus(0, tsspc_pkg::OFS_STATUS, 4'h0);
      check("auto_stop", rv[3], 1'b0);
      bus(0, tsspc_pkg::OFS_TIMER1_CTRL, 4'h0);
      check("disarmed", rv, 32'h4);
      c0 = cnt;
      wave(0, 3);
      check("blocked", cnt - c0, 0);
      int_pin <= 1'b1;
      tick(8);
      bus(1, tsspc_pkg::OFS_INT_CTRL_ONE, 4'h0);
      bus(0, tsspc_pkg::OFS_STATUS, 4'h0);
      check("sync_off", rv[3], 1'b0);
      $display("test sync_start done");
      bus(1, tsspc_pkg::OFS_PIN_EDGE, 4'h0);
      bus(1, tsspc_pkg::OFS_TIMER1_CTRL, 4'h0);
      bus(1, tsspc_pkg::OFS_TIMER1_CTRL, 4'h3);
      bus(1, tsspc_pkg::OFS_TIMER1_CTRL, 4'h7);
      tick(1);
      check("oe_pin_src", pin_oe, 1'b0);
      c0 = cnt;
      wave(1, 3);
      tick(4);
      check("fall_count", cnt - c0, 3);
      bus(1, tsspc_pkg::OFS_PIN_EDGE, 4'h1);
      c0 = cnt;
      wave(1, 2);
      tick(4);
      check("rise_count", cnt - c0, 2);
      $display("test pin_count done");
      bus(1, tsspc_pkg::OFS_TIMER2_CTRL, 4'h2);
      c0 = cnt2;
      wave(2, 3);
      tick(2);
      check("t2_first_rise", cnt2 - c0, 2);
      $display("test timer2_start done");
      final_report();
   end
endmodule // tb_top
